// ===== inc/idac_ref_defines.vh
`ifndef IDAC_REF_DEFINES_VH
`define IDAC_REF_DEFINES_VH

// special-function register addresses
`define ADDR_REFERENCE_CONTROL   8'hd1
`define ADDR_SECOND_DAC_LOW      8'hf4

// reset values
`define RESET_REFERENCE_CONTROL  8'h00
`define RESET_SECOND_DAC_LOW     8'h00

// reference control field positions
`define REF_BUFFER_ENABLE_BIT    0
`define REF_BIAS_ENABLE_BIT      1
`define REF_TEMP_SENSOR_BIT      2
`define REF_SOURCE_SELECT_BIT    3
`define REF_LEVEL_SELECT_BIT     4
`define REF_ZERO_TEMPCO_BIT      5
`define REF_GENERAL_FLAG_BIT     6
`define REF_MERGE_SELECT_BIT     7

// converter control field positions
`define DAC_ENABLE_BIT           7
`define DAC_RIGHT_JUSTIFY_BIT    2

// low byte zero nibble
`define LOW_NIBBLE_ZERO          4'h0

// pin route codes for the second converter
`define ROUTE_PIN_P01            1'b0
`define ROUTE_PIN_P00            1'b1

// per-pin index of the takeover vectors
`define PIN_P00_IDX              0
`define PIN_P01_IDX              1

// released pin: no drive, no pullup
`define PIN_RELEASED_OUT         1'b0
`define PIN_RELEASED_OE_N        1'b1
`define PIN_RELEASED_PULLUP      1'b0

// read data when nothing is selected
`define READ_IDLE_DATA           8'h00

// low byte nibble ranges
`define LOW_UPPER_NIBBLE         7:4
`define LOW_LOWER_NIBBLE         3:0

`endif

// ===== logic/idac_pin_route.v
`timescale 1ns/1ps
`default_nettype none
`include "idac_ref_defines.vh"

// combinational pin routing for the two converter outputs
module idac_pin_route (
   input  wire i_first_enable,
   input  wire i_second_enable,
   input  wire i_merge_select,
   output reg  o_p00_analog,
   output reg  o_p01_analog,
   output reg  o_p00_first,
   output reg  o_p00_second,
   output reg  o_p01_second
);

   // first converter always lands on p0.0; second follows the merge select
   always @* begin
      // [RULE_03] fixed first output
      o_p00_first  = i_first_enable;
      // [RULE_04] merge select routing
      o_p00_second = i_second_enable & (i_merge_select == `ROUTE_PIN_P00);
      o_p01_second = i_second_enable & (i_merge_select == `ROUTE_PIN_P01);
      // [RULE_06] takeover of used pins
      o_p00_analog = o_p00_first | o_p00_second;
      o_p01_analog = o_p01_second;
   end

endmodule // idac_pin_route

`default_nettype wire

// ===== logic/idac_ref_control.v
`timescale 1ns/1ps
`default_nettype none
`include "idac_ref_defines.vh"

// Functional notes
// [RULE_01] left justified: low byte upper nibble holds data bits 3-0, lower nibble zero
// [RULE_02] right justified: low byte holds data bits 7-0 in full
// [RULE_03] first converter output always goes to pin p0.0 only
// [RULE_04] merge select clear routes second converter to p0.1, set to p0.0
// [RULE_05] both enables zero: converter pins act as ordinary gpio
// [RULE_06] an enabled converter's pin loses driver and pullup, joins converter output
// [RULE_07] software skips converter pins in the crossbar
// [RULE_08] both enabled and merged: both outputs combine on p0.0
// [RULE_09] source select zero uses reference pin, one uses supply
// [RULE_10] level select zero gives 1.5 v, one gives 2.2 v
// [RULE_11] buffer enable one drives internal reference onto reference pin
// [RULE_12] software clears buffer enable when internal reference unused
// [RULE_13] bias enable forced one while any bias user is enabled
// [RULE_14] bias enable zero: generator on demand; one: always on
// [RULE_15] zero-tempco bias enable zero: on demand; one: forced on
// [RULE_16] temp sensor enable one: on; zero: sensor high impedance
// [RULE_17] general flag is plain software storage
// [RULE_18] software makes p1.2 analog and skipped when a reference is used
// [RULE_19] converter enable is bit seven of its control register
// [RULE_20] justify select is bit two of its control register
// [RULE_21] writes land on the completing clock edge; registers reset to zero
module idac_ref_control (
   input  wire       i_clk,
   input  wire       i_rst_n,
   input  wire [7:0] i_sfr_addr,
   input  wire [7:0] i_sfr_wdata,
   input  wire       i_sfr_wr,
   input  wire       i_sfr_rd,
   input  wire [7:0] i_first_dac_ctrl,
   input  wire [7:0] i_second_dac_ctrl,
   input  wire       i_adc_enable,
   input  wire       i_osc_enable,
   input  wire       i_ztc_demand,
   input  wire       i_p00_gpio_out,
   input  wire       i_p00_gpio_oe_n,
   input  wire       i_p00_gpio_pullup,
   input  wire       i_p01_gpio_out,
   input  wire       i_p01_gpio_oe_n,
   input  wire       i_p01_gpio_pullup,
   output reg  [7:0] o_sfr_rdata,
   output reg        o_sfr_hit,
   output reg  [7:0] o_second_low_byte,
   output reg  [3:0] o_second_low_bits,
   output reg        o_p00_analog,
   output reg        o_p01_analog,
   output reg        o_p00_first,
   output reg        o_p00_second,
   output reg        o_p01_second,
   output reg        o_p00_out,
   output reg        o_p00_oe_n,
   output reg        o_p00_pullup,
   output reg        o_p01_out,
   output reg        o_p01_oe_n,
   output reg        o_p01_pullup,
   output reg        o_ref_source_supply,
   output reg        o_ref_level_high,
   output reg        o_ref_buffer_on,
   output reg        o_temp_sensor_on,
   output reg        o_bias_on,
   output reg        o_bias_reg_bit,
   output reg        o_zero_tempco_on
);

   // pin count of the takeover logic: p0.0 and p0.1
   localparam PIN_COUNT = 2;

   reg  [7:0] reference_control_reg;
   reg  [7:0] reference_control_next;
   reg  [7:0] second_low_reg;
   reg  [7:0] second_low_next;
   reg  [7:0] read_data_next;
   wire       read_hit;
   wire       bias_force_next;
   wire [1:0] pin_analog;
   wire [1:0] gpio_out;
   wire [1:0] gpio_oe_n;
   wire [1:0] gpio_pullup;
   wire [1:0] pin_out_next;
   wire [1:0] pin_oe_n_next;
   wire [1:0] pin_pullup_next;
   wire       first_enable;
   wire       second_enable;
   wire       second_right;
   wire       bias_demand;
   wire       route_p00_analog;
   wire       route_p01_analog;
   wire       route_p00_first;
   wire       route_p00_second;
   wire       route_p01_second;

   // [RULE_19] enable bits in control bit seven
   assign first_enable  = i_first_dac_ctrl[`DAC_ENABLE_BIT];
   assign second_enable = i_second_dac_ctrl[`DAC_ENABLE_BIT];
   // [RULE_20] justify select at control bit two
   assign second_right  = i_second_dac_ctrl[`DAC_RIGHT_JUSTIFY_BIT];

   // any analog user of the bias generator
   assign bias_demand = i_adc_enable | reference_control_reg[`REF_TEMP_SENSOR_BIT]
                      | i_osc_enable | first_enable | second_enable;

   // routing kept apart so the pin map can be reviewed on its own
   idac_pin_route u_route (
      .i_first_enable  (first_enable),
      .i_second_enable (second_enable),
      .i_merge_select  (reference_control_reg[`REF_MERGE_SELECT_BIT]),
      .o_p00_analog    (route_p00_analog),
      .o_p01_analog    (route_p01_analog),
      .o_p00_first     (route_p00_first),
      .o_p00_second    (route_p00_second),
      .o_p01_second    (route_p01_second)
   );

   // register write decode
   always @* begin
      reference_control_next = reference_control_reg;
      second_low_next        = second_low_reg;
      if (i_sfr_wr) begin
         // [RULE_21] write on completing edge
         if (i_sfr_addr == `ADDR_REFERENCE_CONTROL) begin
            // [RULE_17] flag stored as written
            reference_control_next = i_sfr_wdata;
         end
         if (i_sfr_addr == `ADDR_SECOND_DAC_LOW) begin
            // [RULE_01] left keeps upper nibble
            if (!second_right) begin
               second_low_next = {i_sfr_wdata[`LOW_UPPER_NIBBLE], `LOW_NIBBLE_ZERO};
            end else begin
               // [RULE_02] right keeps full byte
               second_low_next = i_sfr_wdata;
            end
         end
      end
   end

   // [RULE_21] state registers cleared by reset
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         reference_control_reg <= `RESET_REFERENCE_CONTROL;
         second_low_reg        <= `RESET_SECOND_DAC_LOW;
      end else begin
         reference_control_reg <= reference_control_next;
         second_low_reg        <= second_low_next;
      end
   end

   // gather both pins into vectors so the takeover logic is written once
   assign pin_analog[`PIN_P00_IDX]  = route_p00_analog;
   assign pin_analog[`PIN_P01_IDX]  = route_p01_analog;
   assign gpio_out[`PIN_P00_IDX]    = i_p00_gpio_out;
   assign gpio_out[`PIN_P01_IDX]    = i_p01_gpio_out;
   assign gpio_oe_n[`PIN_P00_IDX]   = i_p00_gpio_oe_n;
   assign gpio_oe_n[`PIN_P01_IDX]   = i_p01_gpio_oe_n;
   assign gpio_pullup[`PIN_P00_IDX] = i_p00_gpio_pullup;
   assign gpio_pullup[`PIN_P01_IDX] = i_p01_gpio_pullup;

   // an analog pin is released fully; a live driver or pullup would disturb the converter current
   genvar pin;
   generate
      for (pin = 0; pin < PIN_COUNT; pin = pin + 1) begin : g_pin_drive
         // [RULE_05] gpio passes when unused
         assign pin_out_next[pin]    = pin_analog[pin] ? `PIN_RELEASED_OUT : gpio_out[pin];
         // [RULE_06] driver and pullup off
         assign pin_oe_n_next[pin]   = pin_analog[pin] ? `PIN_RELEASED_OE_N : gpio_oe_n[pin];
         assign pin_pullup_next[pin] = pin_analog[pin] ? `PIN_RELEASED_PULLUP : gpio_pullup[pin];
      end
   endgenerate

   // [RULE_13] forced bias bit
   assign bias_force_next = reference_control_reg[`REF_BIAS_ENABLE_BIT] | bias_demand;

   // mapped read strobe
   assign read_hit = i_sfr_rd & ((i_sfr_addr == `ADDR_REFERENCE_CONTROL)
                               | (i_sfr_addr == `ADDR_SECOND_DAC_LOW));

   // read mux; idle data is zero so several sources can share an or-tree bus
   always @* begin
      // unmapped addresses and idle cycles read as zero
      read_data_next = `READ_IDLE_DATA;
      if (i_sfr_rd && i_sfr_addr == `ADDR_REFERENCE_CONTROL) begin
         read_data_next = reference_control_reg;
         // bias bit reads back forced; the stored bit keeps what software wrote
         read_data_next[`REF_BIAS_ENABLE_BIT] = bias_force_next;
      end else if (i_sfr_rd && i_sfr_addr == `ADDR_SECOND_DAC_LOW) begin
         read_data_next = second_low_reg;
      end
   end

   // read port; data stands for one cycle after the taking edge
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sfr_rdata <= `READ_IDLE_DATA;
         o_sfr_hit   <= 1'b0;
      end else begin
         o_sfr_rdata <= read_data_next;
         o_sfr_hit   <= read_hit;
      end
   end

   // low byte view; the nibble pick follows the justification in force now, not at the write
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_second_low_byte <= `RESET_SECOND_DAC_LOW;
         o_second_low_bits <= `LOW_NIBBLE_ZERO;
      end else begin
         o_second_low_byte <= second_low_reg;
         if (second_right) begin
            // [RULE_02] data bits in lower nibble
            o_second_low_bits <= second_low_reg[`LOW_LOWER_NIBBLE];
         end else begin
            // [RULE_01] data bits in upper nibble
            o_second_low_bits <= second_low_reg[`LOW_UPPER_NIBBLE];
         end
      end
   end

   // routing flags, one cycle behind the enables like every other output
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_p00_first  <= 1'b0;
         o_p00_second <= 1'b0;
         o_p01_second <= 1'b0;
         o_p00_analog <= 1'b0;
         o_p01_analog <= 1'b0;
      end else begin
         // [RULE_03] p0.0 carries first
         o_p00_first  <= route_p00_first;
         // [RULE_08] merged onto p0.0
         o_p00_second <= route_p00_second;
         // [RULE_04] unmerged on p0.1
         o_p01_second <= route_p01_second;
         // [RULE_06] pin taken by a converter
         o_p00_analog <= pin_analog[`PIN_P00_IDX];
         o_p01_analog <= pin_analog[`PIN_P01_IDX];
      end
   end

   // p0.0 drive; reset leaves the pin released until the first clock edge
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_p00_out    <= `PIN_RELEASED_OUT;
         o_p00_oe_n   <= `PIN_RELEASED_OE_N;
         o_p00_pullup <= `PIN_RELEASED_PULLUP;
      end else begin
         o_p00_out    <= pin_out_next[`PIN_P00_IDX];
         o_p00_oe_n   <= pin_oe_n_next[`PIN_P00_IDX];
         o_p00_pullup <= pin_pullup_next[`PIN_P00_IDX];
      end
   end

   // p0.1 drive; taken only while the second converter is enabled and unmerged
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_p01_out    <= `PIN_RELEASED_OUT;
         o_p01_oe_n   <= `PIN_RELEASED_OE_N;
         o_p01_pullup <= `PIN_RELEASED_PULLUP;
      end else begin
         o_p01_out    <= pin_out_next[`PIN_P01_IDX];
         o_p01_oe_n   <= pin_oe_n_next[`PIN_P01_IDX];
         o_p01_pullup <= pin_pullup_next[`PIN_P01_IDX];
      end
   end

   // reference controls are plain copies of their register bits
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ref_source_supply <= 1'b0;
         o_ref_level_high    <= 1'b0;
         o_ref_buffer_on     <= 1'b0;
         o_temp_sensor_on    <= 1'b0;
      end else begin
         // [RULE_09] reference source select
         o_ref_source_supply <= reference_control_reg[`REF_SOURCE_SELECT_BIT];
         // [RULE_10] reference level select
         o_ref_level_high    <= reference_control_reg[`REF_LEVEL_SELECT_BIT];
         // [RULE_11] buffer drives reference pin
         o_ref_buffer_on     <= reference_control_reg[`REF_BUFFER_ENABLE_BIT];
         // [RULE_16] sensor off means high-z
         o_temp_sensor_on    <= reference_control_reg[`REF_TEMP_SENSOR_BIT];
      end
   end

   // bias controls; demand is or-ed in so software cannot switch a needed bias off
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_bias_on      <= 1'b0;
         o_bias_reg_bit <= 1'b0;
      end else begin
         // [RULE_13] forced on by users
         o_bias_reg_bit <= bias_force_next;
         // [RULE_14] on demand or always
         o_bias_on      <= bias_force_next;
      end
   end

   // zero-tempco bias; the demand input comes from the bias users outside this block
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_zero_tempco_on <= 1'b0;
      end else begin
         // [RULE_15] zero-tempco on demand or forced
         o_zero_tempco_on <= reference_control_reg[`REF_ZERO_TEMPCO_BIT] | i_ztc_demand;
      end
   end

endmodule // idac_ref_control

`default_nettype wire

// ===== tb/idac_ref_control_properties.sv
`timescale 1ns/1ps
`default_nettype none
module idac_ref_checker (
   input wire logic       i_clk, i_rst_n, i_sfr_wr, i_sfr_rd, i_adc_enable, i_osc_enable, i_ztc_demand,
   input wire logic [7:0] i_sfr_addr, i_sfr_wdata, i_first_dac_ctrl, i_second_dac_ctrl, o_sfr_rdata,
   input wire logic       o_sfr_hit, o_p00_analog, o_p00_first, o_p00_second, o_p01_second, o_p00_out,
   input wire logic       o_p00_oe_n, o_p00_pullup, o_ref_source_supply, o_ref_level_high, o_ref_buffer_on,
   input wire logic       o_temp_sensor_on, o_bias_on, o_zero_tempco_on
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic [7:0] ref_sh;
   logic [7:0] low_sh;
   logic [1:0] warm;
   wire        e1 = i_first_dac_ctrl[7];
   wire        e2 = i_second_dac_ctrl[7];
   // shadows follow the writes; warm keeps $past away from values taken in reset
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ref_sh <= 8'h00;
         low_sh <= 8'h00;
         warm   <= 2'd0;
      end else begin
         if (!warm[1]) warm <= warm + 2'd1;
         if (i_sfr_wr && i_sfr_addr == 8'hd1) ref_sh <= i_sfr_wdata;
         if (i_sfr_wr && i_sfr_addr == 8'hf4) low_sh <= i_second_dac_ctrl[2] ? i_sfr_wdata : {i_sfr_wdata[7:4], 4'h0};
      end
   end
   first_pin_route_a: assert property (warm[1] |-> o_p00_first == $past(e1))
      else $error("first converter route wrong");
   second_pin_route_a: assert property (warm[1] |-> o_p00_second == $past(e2 & ref_sh[7]) && o_p01_second == $past(e2 & !ref_sh[7]))
      else $error("second converter route wrong");
   pin_takeover_a: assert property (warm[1] |-> o_p00_analog == $past(e1 | e2 & ref_sh[7]) && (!o_p00_analog || {o_p00_out, o_p00_oe_n, o_p00_pullup} == 3'b010))
      else $error("pin takeover wrong");
   merged_outputs_a: assert property (warm[1] && $past(e1 & e2 & ref_sh[7]) |-> o_p00_first && o_p00_second && !o_p01_second)
      else $error("merged outputs wrong");
   ref_bits_a: assert property (warm[1] |-> {o_ref_source_supply, o_ref_level_high, o_ref_buffer_on, o_temp_sensor_on} == $past({ref_sh[3], ref_sh[4], ref_sh[0], ref_sh[2]}))
      else $error("reference outputs wrong");
   bias_forcing_a: assert property (warm[1] |-> o_bias_on == $past(ref_sh[1] | ref_sh[2] | i_adc_enable | i_osc_enable | e1 | e2))
      else $error("bias enable wrong");
   zero_tempco_a: assert property (warm[1] |-> o_zero_tempco_on == $past(ref_sh[5] | i_ztc_demand))
      else $error("zero tempco enable wrong");
   low_byte_read_a: assert property (i_sfr_rd && !i_sfr_wr && i_sfr_addr == 8'hf4 |=> o_sfr_hit && o_sfr_rdata == low_sh)
      else $error("low byte read wrong");
   ref_read_a: assert property (i_sfr_rd && !i_sfr_wr && i_sfr_addr == 8'hd1 |=> o_sfr_hit && {o_sfr_rdata[7:2], o_sfr_rdata[0]} == {ref_sh[7:2], ref_sh[0]})
      else $error("reference read wrong");
   unmapped_read_a: assert property (i_sfr_rd && i_sfr_addr != 8'hd1 && i_sfr_addr != 8'hf4 |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
      else $error("unmapped read not empty");
   merged_seen_c: cover property (o_p00_first && o_p00_second);
   forced_bias_c: cover property (o_bias_on && !ref_sh[1]);
   unmapped_seen_c: cover property (i_sfr_rd && i_sfr_addr == 8'hd2);
endmodule // idac_ref_checker
bind idac_ref_control idac_ref_checker chk (.*);
`default_nettype wire

// ===== tb/idac_ref_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module idac_ref_control_tb;
   logic       i_clk, i_rst_n, i_sfr_wr, i_sfr_rd, i_adc_enable, i_osc_enable, i_ztc_demand, o_bias_reg_bit;
   logic       i_p00_gpio_out, i_p00_gpio_oe_n, i_p00_gpio_pullup, i_p01_gpio_out, i_p01_gpio_oe_n, i_p01_gpio_pullup;
   logic [7:0] i_sfr_addr, i_sfr_wdata, i_first_dac_ctrl, i_second_dac_ctrl, o_sfr_rdata, o_second_low_byte;
   logic [3:0] o_second_low_bits;
   logic       o_sfr_hit, o_p00_analog, o_p01_analog, o_p00_first, o_p00_second, o_p01_second, o_p00_out;
   logic       o_p00_oe_n, o_p00_pullup, o_p01_out, o_p01_oe_n, o_p01_pullup, o_ref_source_supply, o_ref_level_high;
   logic       o_ref_buffer_on, o_temp_sensor_on, o_bias_on, o_zero_tempco_on;
   int         bad_count = 0, checks_done = 0, cycles = 0;
   idac_ref_control dut (.*);
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // the whole run needs about 120 cycles; a hang is cut off well past that
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         end_sim;
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      {i_sfr_addr, i_sfr_wdata, i_sfr_wr} = {a, d, 1'b1};
      @(negedge i_clk);
      i_sfr_wr = 1'b0;
      repeat (2) @(negedge i_clk);
   endtask
   // read data stands one cycle, so it is looked at on the half cycle after the taking edge
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
      @(negedge i_clk);
      {i_sfr_addr, i_sfr_rd} = {a, 1'b1};
      @(negedge i_clk);
      i_sfr_rd = 1'b0;
      chk("read data", e, o_sfr_rdata);
      chk("read hit", {7'h0, h}, {7'h0, o_sfr_hit});
   endtask
   initial begin
      {i_sfr_wr, i_sfr_rd, i_adc_enable, i_osc_enable, i_ztc_demand, i_sfr_addr, i_sfr_wdata} = 21'h0;
      {i_p00_gpio_out, i_p00_gpio_oe_n, i_p00_gpio_pullup, i_p01_gpio_out, i_p01_gpio_oe_n, i_p01_gpio_pullup} = 6'h2b;
      {i_first_dac_ctrl, i_second_dac_ctrl, i_rst_n} = 17'h0;
      repeat (6) @(negedge i_clk);
      i_rst_n = 1'b1;
      rd(8'hd1, 8'h00, 1'b1);
      rd(8'hf4, 8'h00, 1'b1);
      // left justified keeps only the upper nibble
      wr(8'hf4, 8'ha5);
      rd(8'hf4, 8'ha0, 1'b1);
      chk("low bits", 8'h0a, {4'h0, o_second_low_bits});
      i_second_dac_ctrl = 8'h04;
      wr(8'hf4, 8'h5b);
      rd(8'hf4, 8'h5b, 1'b1);
      chk("low bits", 8'h0b, {4'h0, o_second_low_bits});
      chk("low byte", 8'h5b, o_second_low_byte);
      // unmapped place takes nothing and reads empty
      wr(8'hd2, 8'hff);
      rd(8'hd2, 8'h00, 1'b0);
      rd(8'hd1, 8'h00, 1'b1);
      // p1.2 analog setup belongs to port software; only the reference bits are driven here
      // reference bits 0 to 6 alone, temp sensor also forces bias
      for (int b = 0; b < 7; b++) begin
         wr(8'hd1, 8'h01 << b);
         rd(8'hd1, (8'h01 << b) | ((b == 2) ? 8'h02 : 8'h00), 1'b1);
         chk("ref outputs", {2'b0, 6'h01 << b} | ((b == 2) ? 8'h02 : 8'h00), {2'b0, o_zero_tempco_on, o_ref_level_high,
             o_ref_source_supply, o_temp_sensor_on, o_bias_on, o_ref_buffer_on});
      end
      wr(8'hd1, 8'h00);
      // every bias user forces the bias bit
      for (int u = 0; u < 4; u++) begin
         {i_adc_enable, i_osc_enable, i_first_dac_ctrl[7], i_second_dac_ctrl[7]} = 4'h1 << u;
         rd(8'hd1, 8'h02, 1'b1);
         chk("bias on", 8'h01, {7'h0, o_bias_on});
         chk("bias bit", 8'h01, {7'h0, o_bias_reg_bit});
      end
      // the last user left on by the loop is the adc enable; drop it before the idle check
      {i_adc_enable, i_ztc_demand} = 2'b01;
      repeat (2) @(negedge i_clk);
      chk("bias idle ztc demand", 8'h01, {5'h0, o_bias_reg_bit, o_bias_on, o_zero_tempco_on});
      i_ztc_demand = 1'b0;
      // crossbar skip is set by port software; the pins here are taken over regardless
      for (int k = 0; k < 8; k++) begin
         {i_first_dac_ctrl, i_second_dac_ctrl} = {k[0], 7'h00, k[1], 7'h04};
         wr(8'hd1, {k[2], 7'h00});
         chk("routes", {3'b0, k[0], k[1] & k[2], k[1] & !k[2], k[0] | k[1] & k[2], k[1] & !k[2]},
             {3'b0, o_p00_first, o_p00_second, o_p01_second, o_p00_analog, o_p01_analog});
         chk("p00 pin", (k[0] | k[1] & k[2]) ? 8'h02 : 8'h05, {5'h0, o_p00_out, o_p00_oe_n, o_p00_pullup});
         chk("p01 pin", (k[1] & !k[2]) ? 8'h02 : 8'h03, {5'h0, o_p01_out, o_p01_oe_n, o_p01_pullup});
      end
      end_sim;
   end
endmodule // idac_ref_control_tb
`default_nettype wire
